//--- logic/ienp_pkg.sv
// Register map, source bit layout and bus carrier for the interrupt enable/pending block
package ienp_pkg;

   localparam int unsigned DATA_W = 32;
   localparam int unsigned ADDR_W = 32;

   // Register byte addresses
   localparam logic [ADDR_W-1:0] OFS_EN_SET   = 32'hE000E100;
   localparam logic [ADDR_W-1:0] OFS_EN_CLR   = 32'hE000E180;
   localparam logic [ADDR_W-1:0] OFS_PD_SET   = 32'hE000E200;
   localparam logic [ADDR_W-1:0] OFS_PD_CLR   = 32'hE000E280;
   localparam logic [ADDR_W-1:0] OFS_EVT_STAT = 32'hE000E300;
   localparam logic [ADDR_W-1:0] OFS_EVT_CLR  = 32'hE000E304;
   localparam logic [ADDR_W-1:0] OFS_EVT_EN   = 32'hE000E308;

   // Source bit positions, shared by every enable and pending register
   localparam int unsigned BIT_DEBUG      = 16;
   localparam int unsigned BIT_EXT_D      = 15;
   localparam int unsigned BIT_EXT_C      = 14;
   localparam int unsigned BIT_EXT_A      = 12;
   localparam int unsigned BIT_LINK_RX    = 10;
   localparam int unsigned BIT_LINK_TX    = 9;
   localparam int unsigned BIT_LINK_TMR   = 8;
   localparam int unsigned BIT_SECURITY   = 7;
   localparam int unsigned BIT_SERIAL_ONE = 5;
   localparam int unsigned BIT_SLEEP_TMR  = 4;
   localparam int unsigned BIT_BASEBAND   = 3;
   localparam int unsigned BIT_MANAGEMENT = 2;

   localparam logic [DATA_W-1:0] ONE_HOT = 32'h00000001;

   localparam logic [DATA_W-1:0] GRP_EXT_MASK =
      (ONE_HOT << BIT_EXT_D) | (ONE_HOT << BIT_EXT_C) | (ONE_HOT << BIT_EXT_A);
   localparam logic [DATA_W-1:0] GRP_LINK_MASK =
      (ONE_HOT << BIT_LINK_RX) | (ONE_HOT << BIT_LINK_TX) | (ONE_HOT << BIT_LINK_TMR);
   localparam logic [DATA_W-1:0] GRP_SEC_SER_MASK =
      (ONE_HOT << BIT_SECURITY) | (ONE_HOT << BIT_SERIAL_ONE);
   localparam logic [DATA_W-1:0] GRP_SYS_MASK =
      (ONE_HOT << BIT_SLEEP_TMR) | (ONE_HOT << BIT_BASEBAND) |
      (ONE_HOT << BIT_MANAGEMENT) | (ONE_HOT << BIT_DEBUG);
   localparam logic [DATA_W-1:0] SRC_MASK =
      GRP_EXT_MASK | GRP_LINK_MASK | GRP_SEC_SER_MASK | GRP_SYS_MASK;

   localparam logic [DATA_W-1:0] RESET_VAL = 32'h00000000;

   // Block events that feed the sticky status register
   localparam int unsigned EVT_W       = 2;
   localparam int unsigned EVT_REQ_NEW = 0;
   localparam int unsigned EVT_OVERRUN = 1;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } ienp_bus_t;

endpackage

//--- logic/ienp_bit_cell.sv
// One source's enable and pending state with its core request
`timescale 1ns/1ps
`default_nettype none
module ienp_bit_cell (
   input  wire logic mclk_in,    // System clock
   input  wire logic rstn_in,    // Synchronous reset, active low
   input  wire logic en_set_in,  // Write one to enable-set
   input  wire logic en_clr_in,  // Write one to enable-clear
   input  wire logic pd_set_in,  // Write one to pending-set
   input  wire logic pd_clr_in,  // Write one to pending-clear
   input  wire logic src_in,     // Source event, same clock
   output logic      en_out,     // Enable state
   output logic      pd_out,     // Pending state
   output logic      req_out     // Enabled and pending
);
   logic en_nxt;
   logic pd_nxt;

   // Set and clear never come in one write, so order does not matter here
   assign en_nxt = (en_out | en_set_in) & ~en_clr_in;
   // A source event in the clear cycle is kept: set wins
   assign pd_nxt = (pd_out & ~pd_clr_in) | pd_set_in | src_in;

   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         en_out  <= 1'b0;
         pd_out  <= 1'b0;
         req_out <= 1'b0;
      end else begin
         en_out  <= en_nxt;
         pd_out  <= pd_nxt;
         req_out <= en_nxt & pd_nxt;
      end
   end
endmodule
`default_nettype wire

//--- logic/ienp_evt_stat.sv
// Sticky event status with write-one-to-clear, enable mask and level interrupt
`timescale 1ns/1ps
`default_nettype none
module ienp_evt_stat #(
   parameter int unsigned W = 2
) (
   input  wire logic         mclk_in,    // System clock
   input  wire logic         rstn_in,    // Synchronous reset, active low
   input  wire logic [W-1:0] evt_in,     // One-cycle event pulses
   input  wire logic         clr_wr_in,  // Write to the clear register
   input  wire logic         en_wr_in,   // Write to the enable register
   input  wire logic [W-1:0] wdata_in,   // Write data, low bits
   output logic      [W-1:0] stat_out,   // Sticky status
   output logic      [W-1:0] en_out,     // Enable mask
   output logic              irq_out     // Level interrupt
);
   logic [W-1:0] stat_nxt;
   logic [W-1:0] en_nxt;

   assign stat_nxt = (stat_out & ~(clr_wr_in ? wdata_in : '0)) | evt_in;
   assign en_nxt   = en_wr_in ? wdata_in : en_out;

   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         stat_out <= '0;
         en_out   <= '0;
         irq_out  <= 1'b0;
      end else begin
         stat_out <= stat_nxt;
         en_out   <= en_nxt;
         irq_out  <= |(stat_nxt & en_nxt);
      end
   end
endmodule
`default_nettype wire

//--- logic/ienp_top.sv
// Top-level interrupt enable and pending registers with register port and event status
//
// Functional notes
// - A one written to a bit of the enable-set register enables that source.
// - Zero bits written to the enable-set register leave those enables as they were.
// - A one written to a bit of the enable-clear register disables that source.
// - Zero bits written to the enable-clear register leave those enables as they were.
// - A one written to a bit of the pending-set register pends that source like a real event.
// - Zero bits written to the pending-set register leave those pending states alone.
// - External lines D, C and A sit at bits 15, 14 and 12 of every such register.
// - Link receive, transmit and timer sources sit at bits 10, 9 and 8.
// - The security source sits at bit 7 and the first serial controller at bit 5.
// - Sleep timer, baseband and management sit at bits 4, 3, 2 and debug at bit 16.
// - A one written to the pending-clear register unpends that source unless the source fires in that cycle; zeros do nothing.
`timescale 1ns/1ps
`default_nettype none
module ienp_top (
   input  wire logic                      mclk_in,       // System clock, 20 MHz
   input  wire logic                      rstn_in,       // Synchronous reset, active low
   input  wire ienp_pkg::ienp_bus_t       bus_in,        // Register port request
   input  wire logic [ienp_pkg::DATA_W-1:0] src_in,      // Source event lines
   output logic      [ienp_pkg::DATA_W-1:0] rdata_out,   // Read data, cycle after read
   output logic      [ienp_pkg::DATA_W-1:0] irq_req_out, // Per-source core request
   output logic                           irq_out        // Block event interrupt
);

   // Address decode
   wire hit_en_set   = (bus_in.addr == ienp_pkg::OFS_EN_SET);
   wire hit_en_clr   = (bus_in.addr == ienp_pkg::OFS_EN_CLR);
   wire hit_pd_set   = (bus_in.addr == ienp_pkg::OFS_PD_SET);
   wire hit_pd_clr   = (bus_in.addr == ienp_pkg::OFS_PD_CLR);
   wire hit_evt_stat = (bus_in.addr == ienp_pkg::OFS_EVT_STAT);
   wire hit_evt_clr  = (bus_in.addr == ienp_pkg::OFS_EVT_CLR);
   wire hit_evt_en   = (bus_in.addr == ienp_pkg::OFS_EVT_EN);

   // Write strobes
   wire wr_en_set  = bus_in.wr & hit_en_set;
   wire wr_en_clr  = bus_in.wr & hit_en_clr;
   wire wr_pd_set  = bus_in.wr & hit_pd_set;
   wire wr_pd_clr  = bus_in.wr & hit_pd_clr;
   wire wr_evt_clr = bus_in.wr & hit_evt_clr;
   wire wr_evt_en  = bus_in.wr & hit_evt_en;

   // Only mapped source bits reach the cells; the rest of the word is dropped
   wire [ienp_pkg::DATA_W-1:0] wmask   = bus_in.wdata & ienp_pkg::SRC_MASK;
   wire [ienp_pkg::DATA_W-1:0] src_msk = src_in & ienp_pkg::SRC_MASK;

   wire [ienp_pkg::DATA_W-1:0] en_vec;
   wire [ienp_pkg::DATA_W-1:0] pd_vec;
   wire [ienp_pkg::DATA_W-1:0] req_vec;

   // One cell per mapped source; the same index serves all four registers
   for (genvar i = 0; i < ienp_pkg::DATA_W; i++) begin : g_src
      if (ienp_pkg::SRC_MASK[i]) begin : g_cell
         ienp_bit_cell u_cell (
            .mclk_in   (mclk_in),
            .rstn_in   (rstn_in),
            .en_set_in (wr_en_set & wmask[i]),
            .en_clr_in (wr_en_clr & wmask[i]),
            .pd_set_in (wr_pd_set & wmask[i]),
            .pd_clr_in (wr_pd_clr & wmask[i]),
            .src_in    (src_msk[i]),
            .en_out    (en_vec[i]),
            .pd_out    (pd_vec[i]),
            .req_out   (req_vec[i])
         );
      end else begin : g_rsvd
         assign en_vec[i]  = 1'b0;
         assign pd_vec[i]  = 1'b0;
         assign req_vec[i] = 1'b0;
      end
   end

   assign irq_req_out = req_vec;

   // Block events: the core request goes from none to any, or a source fires while already pending
   logic req_any_r;
   wire  req_any  = |req_vec;
   wire  req_new  = req_any & ~req_any_r;
   wire  overrun  = |(src_msk & pd_vec);
   wire [ienp_pkg::EVT_W-1:0] evt_vec;
   wire [ienp_pkg::EVT_W-1:0] evt_stat;
   wire [ienp_pkg::EVT_W-1:0] evt_en;

   assign evt_vec[ienp_pkg::EVT_REQ_NEW] = req_new;
   assign evt_vec[ienp_pkg::EVT_OVERRUN] = overrun;

   ienp_evt_stat #(
      .W (ienp_pkg::EVT_W)
   ) u_evt (
      .mclk_in   (mclk_in),
      .rstn_in   (rstn_in),
      .evt_in    (evt_vec),
      .clr_wr_in (wr_evt_clr),
      .en_wr_in  (wr_evt_en),
      .wdata_in  (bus_in.wdata[ienp_pkg::EVT_W-1:0]),
      .stat_out  (evt_stat),
      .en_out    (evt_en),
      .irq_out   (irq_out)
   );

   // Read selection; unmapped and write-only addresses return zero
   wire [ienp_pkg::DATA_W-1:0] evt_stat_w = {{(ienp_pkg::DATA_W-ienp_pkg::EVT_W){1'b0}}, evt_stat};
   wire [ienp_pkg::DATA_W-1:0] evt_en_w   = {{(ienp_pkg::DATA_W-ienp_pkg::EVT_W){1'b0}}, evt_en};
   wire [ienp_pkg::DATA_W-1:0] rd_mux =
      (hit_en_set | hit_en_clr) ? en_vec :
      (hit_pd_set | hit_pd_clr) ? pd_vec :
      hit_evt_stat              ? evt_stat_w :
      hit_evt_en                ? evt_en_w :
                                  ienp_pkg::RESET_VAL;

   // Read data lives for exactly one cycle after the strobe
   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         rdata_out <= ienp_pkg::RESET_VAL;
         req_any_r <= 1'b0;
      end else begin
         rdata_out <= bus_in.rd ? rd_mux : ienp_pkg::RESET_VAL;
         req_any_r <= req_any;
      end
   end

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!rstn_in);

   sequence s_wr_en_set;
      bus_in.wr && hit_en_set;
   endsequence

   sequence s_wr_en_clr;
      bus_in.wr && hit_en_clr;
   endsequence

   sequence s_wr_pd_set;
      bus_in.wr && hit_pd_set;
   endsequence

   sequence s_wr_pd_clr_quiet;
      bus_in.wr && hit_pd_clr && ((src_in & bus_in.wdata) == '0);
   endsequence

   sequence s_rd_en;
      bus_in.rd && (hit_en_set || hit_en_clr);
   endsequence

   en_set_ones_a: assert property (
      s_wr_en_set |=> ((en_vec & $past(wmask)) == $past(wmask)))
      else $error("enable-set did not enable written sources");

   en_set_zeros_a: assert property (
      s_wr_en_set |=> ((en_vec & ~$past(bus_in.wdata)) == ($past(en_vec) & ~$past(bus_in.wdata))))
      else $error("enable-set zero bits changed enables");

   en_clr_ones_a: assert property (
      s_wr_en_clr |=> ((en_vec & $past(bus_in.wdata)) == '0))
      else $error("enable-clear did not disable written sources");

   en_clr_zeros_a: assert property (
      s_wr_en_clr |=> ((en_vec & ~$past(bus_in.wdata)) == ($past(en_vec) & ~$past(bus_in.wdata))))
      else $error("enable-clear zero bits changed enables");

   pd_set_ones_a: assert property (
      s_wr_pd_set |=> ((pd_vec & $past(wmask)) == $past(wmask))
         && ((irq_req_out & $past(wmask)) == (en_vec & $past(wmask))))
      else $error("pending-set did not raise the enabled request");

   pd_set_zeros_a: assert property (
      (s_wr_pd_set and (src_in == '0))
      |=> ((pd_vec & ~$past(bus_in.wdata)) == ($past(pd_vec) & ~$past(bus_in.wdata))))
      else $error("pending-set zero bits changed pending");

   pd_clr_a: assert property (
      s_wr_pd_clr_quiet |=> ((pd_vec & $past(bus_in.wdata)) == '0)
         && ((pd_vec & ~$past(bus_in.wdata)) ==
             (($past(pd_vec) | $past(src_msk)) & ~$past(bus_in.wdata))))
      else $error("pending-clear misbehaved");

   src_ext_map_a: assert property (
      ((src_in & ienp_pkg::GRP_EXT_MASK) != '0)
      |=> ((pd_vec & $past(src_in) & ienp_pkg::GRP_EXT_MASK) ==
           ($past(src_in) & ienp_pkg::GRP_EXT_MASK)))
      else $error("external line not pended at its bit");

   src_link_map_a: assert property (
      ((src_in & ienp_pkg::GRP_LINK_MASK) != '0)
      |=> ((pd_vec & $past(src_in) & ienp_pkg::GRP_LINK_MASK) ==
           ($past(src_in) & ienp_pkg::GRP_LINK_MASK)))
      else $error("link source not pended at its bit");

   src_secser_map_a: assert property (
      ((src_in & ienp_pkg::GRP_SEC_SER_MASK) != '0)
      |=> ((pd_vec & $past(src_in) & ienp_pkg::GRP_SEC_SER_MASK) ==
           ($past(src_in) & ienp_pkg::GRP_SEC_SER_MASK)))
      else $error("security or serial source not pended at its bit");

   src_sys_map_a: assert property (
      ((src_in & ienp_pkg::GRP_SYS_MASK) != '0)
      |=> ((pd_vec & $past(src_in) & ienp_pkg::GRP_SYS_MASK) ==
           ($past(src_in) & ienp_pkg::GRP_SYS_MASK)))
      else $error("system source not pended at its bit");

   rsvd_zero_a: assert property (
      bus_in.rd && (hit_en_set || hit_pd_set)
      |=> ((rdata_out & ~ienp_pkg::SRC_MASK) == '0) && ((irq_req_out & ~ienp_pkg::SRC_MASK) == '0))
      else $error("reserved bit read or requested as nonzero");

   rd_enable_a: assert property (
      s_rd_en |=> (rdata_out == $past(en_vec)))
      else $error("enable read did not return enable state");

   core_req_a: assert property (
      (irq_req_out == (en_vec & pd_vec)) && (irq_out == |(evt_stat & evt_en)))
      else $error("request outputs disagree with state");

   rd_one_cycle_a: assert property (
      !bus_in.rd |=> (rdata_out == ienp_pkg::RESET_VAL))
      else $error("read data held beyond its cycle");

   // Read side: each register shows its own state, everything else reads zero
   wire rd_none = ~(hit_en_set | hit_en_clr | hit_pd_set | hit_pd_clr |
                    hit_evt_stat | hit_evt_en);

   sequence s_rd_pd;
      bus_in.rd && (hit_pd_set || hit_pd_clr);
   endsequence

   rd_pending_a: assert property (
      s_rd_pd |=> (rdata_out == $past(pd_vec)))
      else $error("pending read did not return pending state");

   rd_evt_stat_a: assert property (
      bus_in.rd && hit_evt_stat |=> (rdata_out == $past(evt_stat_w)))
      else $error("event status read did not return status");

   rd_evt_en_a: assert property (
      bus_in.rd && hit_evt_en |=> (rdata_out == $past(evt_en_w)))
      else $error("event enable read did not return the mask");

   rd_unmapped_a: assert property (
      bus_in.rd && rd_none |=> (rdata_out == ienp_pkg::RESET_VAL))
      else $error("unmapped or write-only read returned nonzero");

   // A write to one register must leave the others alone
   sequence s_no_en_wr;
      !(bus_in.wr && (hit_en_set || hit_en_clr));
   endsequence

   sequence s_no_pd_change;
      !(bus_in.wr && (hit_pd_set || hit_pd_clr)) && (src_msk == '0);
   endsequence

   en_hold_a: assert property (
      s_no_en_wr |=> $stable(en_vec))
      else $error("enables changed without an enable write");

   pd_hold_a: assert property (
      s_no_pd_change |=> $stable(pd_vec))
      else $error("pending changed without a write or source");

   evt_en_hold_a: assert property (
      !(bus_in.wr && hit_evt_en) |=> $stable(evt_en))
      else $error("event enable changed without a write");

   evt_stat_hold_a: assert property (
      !(bus_in.wr && hit_evt_clr) && (evt_vec == '0)
      |=> $stable(evt_stat))
      else $error("event status changed without cause");

   // Enable state seen by a later read, with no enable write between
   rd_after_wr_a: assert property (
      s_wr_en_set ##1 s_no_en_wr ##1 s_rd_en
      |=> ((rdata_out & $past(wmask, 3)) == $past(wmask, 3)))
      else $error("enabled source missing from a later read");

   en_clr_rd_a: assert property (
      s_wr_en_clr ##1 s_no_en_wr ##1 s_rd_en
      |=> ((rdata_out & $past(wmask, 3)) == '0))
      else $error("disabled source still reads as enabled");

   // Request outputs follow every enable and pending change after one edge
   req_set_a: assert property (
      s_wr_en_set |=> ((irq_req_out & $past(wmask)) == (pd_vec & $past(wmask))))
      else $error("enabling a pending source did not request the core");

   req_drop_a: assert property (
      s_wr_en_clr |=> ((irq_req_out & $past(wmask)) == '0))
      else $error("disabled source still requests the core");

   pd_clr_req_a: assert property (
      s_wr_pd_clr_quiet |=> ((irq_req_out & $past(bus_in.wdata)) == '0))
      else $error("unpended source still requests the core");

   // A source in the same cycle as its pending-clear must not be lost
   src_wins_a: assert property (
      bus_in.wr && hit_pd_clr && (src_msk != '0)
      |=> ((pd_vec & $past(src_msk)) == $past(src_msk)))
      else $error("source event lost against pending-clear");

   // Pending-set and a real source land in the same state
   pd_like_src_a: assert property (
      s_wr_pd_set |=> ((pd_vec & $past(wmask | src_msk)) == $past(wmask | src_msk)))
      else $error("pending-set and source did not both pend");

   // Block events: a request rising from idle, a source finding its bit pending
   sequence s_req_rise;
      !req_any ##1 req_any;
   endsequence

   req_new_evt_a: assert property (
      s_req_rise |=> evt_stat[ienp_pkg::EVT_REQ_NEW])
      else $error("new request not latched as an event");

   overrun_evt_a: assert property (
      ((src_msk & pd_vec) != '0) |=> evt_stat[ienp_pkg::EVT_OVERRUN])
      else $error("overrun not latched as an event");

   evt_clr_a: assert property (
      bus_in.wr && hit_evt_clr && (evt_vec == '0)
      |=> ((evt_stat & $past(bus_in.wdata[ienp_pkg::EVT_W-1:0])) == '0))
      else $error("event clear left a written bit set");

   // Set wins: an event in the clear cycle survives it
   evt_set_wins_a: assert property (
      bus_in.wr && hit_evt_clr && (evt_vec != '0)
      |=> ((evt_stat & $past(evt_vec)) == $past(evt_vec)))
      else $error("event lost against its clear");

   evt_en_wr_a: assert property (
      bus_in.wr && hit_evt_en
      |=> (evt_en == $past(bus_in.wdata[ienp_pkg::EVT_W-1:0])))
      else $error("event enable write did not land");

   evt_stat_ro_a: assert property (
      bus_in.wr && hit_evt_stat && (evt_vec == '0) |=> $stable(evt_stat))
      else $error("event status took a write");

   irq_mask_a: assert property (
      bus_in.wr && hit_evt_en && (bus_in.wdata[ienp_pkg::EVT_W-1:0] == '0)
      |=> !irq_out)
      else $error("masked block interrupt still raised");

endmodule
`default_nettype wire

//--- verif/ienp_core_model.sv
// Behavioural core exception entry: records every request line it has seen
`timescale 1ns/1ps
`default_nettype none
module ienp_core_model (
   input  wire logic        mclk_in,   // System clock
   input  wire logic        rstn_in,   // Synchronous reset, active low
   input  wire logic [31:0] req_in,    // Per-source requests from the block
   output logic      [31:0] seen_out   // Requests taken since reset
);
   // No acknowledge path exists, so the core only samples the request levels
   always_ff @(posedge mclk_in) begin
      if (!rstn_in) begin
         seen_out <= 32'h00000000;
      end else begin
         seen_out <= seen_out | req_in;
      end
   end
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// Self-checking bench for the interrupt enable and pending registers
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam logic [31:0] SRC_EXP = 32'h0001D7BC;
   logic                mclk_in;
   logic                rstn_in;
   ienp_pkg::ienp_bus_t bus;
   logic [31:0]         src;
   logic [31:0]         rdata;
   logic [31:0]         req;
   logic                irq;
   logic [31:0]         seen;
   int                  failures;
   int                  checked;
   int unsigned         bits [12] = '{16, 15, 14, 12, 10, 9, 8, 7, 5, 4, 3, 2};

   ienp_top uut (
      .mclk_in     (mclk_in),
      .rstn_in     (rstn_in),
      .bus_in      (bus),
      .src_in      (src),
      .rdata_out   (rdata),
      .irq_req_out (req),
      .irq_out     (irq)
   );

   ienp_core_model core (
      .mclk_in  (mclk_in),
      .rstn_in  (rstn_in),
      .req_in   (req),
      .seen_out (seen)
   );

   initial begin
      mclk_in = 1'b0;
      forever #25 mclk_in = ~mclk_in;
   end

   task automatic summarize();
      if (failures == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t seen=%h expected=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge mclk_in);
      bus.wr    <= 1'b1;
      bus.addr  <= a;
      bus.wdata <= d;
      @(posedge mclk_in);
      bus.wr    <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so sample just past that edge
   task automatic rd(input logic [31:0] a, input logic [31:0] exp);
      @(posedge mclk_in);
      bus.rd   <= 1'b1;
      bus.addr <= a;
      @(posedge mclk_in);
      bus.rd   <= 1'b0;
      #1;
      check(rdata, exp);
   endtask

   task automatic pulse_src(input logic [31:0] v);
      @(posedge mclk_in);
      src <= v;
      @(posedge mclk_in);
      src <= 32'h00000000;
   endtask

   task automatic do_reset();
      @(posedge mclk_in);
      rstn_in <= 1'b0;
      repeat (6) @(posedge mclk_in);
      rstn_in <= 1'b1;
   endtask

   // Watchdog cuts a hang short
   initial begin
      #2000000;
      failures++;
      summarize();
   end

   initial begin
      logic [31:0] regs [6];
      logic [31:0] b;
      regs = '{ienp_pkg::OFS_EN_SET, ienp_pkg::OFS_EN_CLR, ienp_pkg::OFS_PD_SET,
               ienp_pkg::OFS_PD_CLR, ienp_pkg::OFS_EVT_STAT, ienp_pkg::OFS_EVT_EN};
      failures = 0;
      checked  = 0;
      rstn_in  = 1'b0;
      bus      = '0;
      src      = 32'h00000000;
      do_reset();
      foreach (regs[i]) rd(regs[i], 32'h00000000);
      check(req, 32'h00000000);
      wr(ienp_pkg::OFS_EN_SET, 32'hFFFFFFFF);
      rd(ienp_pkg::OFS_EN_SET, SRC_EXP);
      rd(ienp_pkg::OFS_EN_CLR, SRC_EXP);
      wr(ienp_pkg::OFS_EN_SET, 32'h00000000);
      rd(ienp_pkg::OFS_EN_SET, SRC_EXP);
      wr(ienp_pkg::OFS_EN_CLR, ~SRC_EXP | 32'h00008000);
      rd(ienp_pkg::OFS_EN_SET, SRC_EXP & 32'hFFFF7FFF);
      wr(ienp_pkg::OFS_EN_CLR, 32'h00000000);
      rd(ienp_pkg::OFS_EN_SET, SRC_EXP & 32'hFFFF7FFF);
      wr(ienp_pkg::OFS_EN_SET, 32'h00008000);
      wr(ienp_pkg::OFS_PD_SET, ~SRC_EXP);
      rd(ienp_pkg::OFS_PD_SET, 32'h00000000);
      check(req, 32'h00000000);
      // Each source alone: pend, read back, request, then unpend
      foreach (bits[i]) begin
         b = 32'h00000001 << bits[i];
         wr(ienp_pkg::OFS_PD_SET, b);
         wr(ienp_pkg::OFS_PD_SET, 32'h00000000);
         rd(ienp_pkg::OFS_PD_SET, b);
         check(req, b);
         wr(ienp_pkg::OFS_PD_CLR, 32'h00000000);
         rd(ienp_pkg::OFS_PD_CLR, b);
         wr(ienp_pkg::OFS_PD_CLR, b);
         rd(ienp_pkg::OFS_PD_SET, 32'h00000000);
      end
      check(seen, SRC_EXP);
      // A pending source that is disabled must not reach the core
      wr(ienp_pkg::OFS_EN_CLR, 32'h00008000);
      wr(ienp_pkg::OFS_PD_SET, 32'h00008000);
      rd(ienp_pkg::OFS_PD_SET, 32'h00008000);
      check(req, 32'h00000000);
      wr(ienp_pkg::OFS_PD_CLR, 32'h00008000);
      wr(32'hE000E400, 32'hFFFFFFFF);
      rd(32'hE000E400, 32'h00000000);
      rd(ienp_pkg::OFS_EN_SET, SRC_EXP & 32'hFFFF7FFF);
      // Block interrupt: raise, overrun, mask, clear
      wr(ienp_pkg::OFS_EVT_CLR, 32'h00000003);
      rd(ienp_pkg::OFS_EVT_STAT, 32'h00000000);
      wr(ienp_pkg::OFS_EVT_EN, 32'h00000003);
      check({31'h0, irq}, 32'h00000000);
      pulse_src(32'h00000010);
      rd(ienp_pkg::OFS_PD_SET, 32'h00000010);
      check(req, 32'h00000010);
      rd(ienp_pkg::OFS_EVT_STAT, 32'h00000001);
      check({31'h0, irq}, 32'h00000001);
      pulse_src(32'h00000010);
      rd(ienp_pkg::OFS_EVT_STAT, 32'h00000003);
      wr(ienp_pkg::OFS_EVT_STAT, 32'h00000000);
      wr(ienp_pkg::OFS_EVT_EN, 32'h00000000);
      rd(ienp_pkg::OFS_EVT_EN, 32'h00000000);
      check({31'h0, irq}, 32'h00000000);
      wr(ienp_pkg::OFS_EVT_EN, 32'h00000003);
      rd(ienp_pkg::OFS_EVT_STAT, 32'h00000003);
      check({31'h0, irq}, 32'h00000001);
      wr(ienp_pkg::OFS_EVT_CLR, 32'h00000003);
      rd(ienp_pkg::OFS_EVT_STAT, 32'h00000000);
      check({31'h0, irq}, 32'h00000000);
      rd(ienp_pkg::OFS_EVT_CLR, 32'h00000000);
      // Reset in mid-run returns every state to zero
      do_reset();
      rd(ienp_pkg::OFS_EN_SET, 32'h00000000);
      rd(ienp_pkg::OFS_PD_SET, 32'h00000000);
      check(req, 32'h00000000);
      rd(ienp_pkg::OFS_EVT_STAT, 32'h00000000);
      check({31'h0, irq}, 32'h00000000);
      // Every line at once: mapped ones pend, the rest are ignored
      pulse_src(32'hFFFFFFFF);
      rd(ienp_pkg::OFS_PD_SET, SRC_EXP);
      check(req, 32'h00000000);
      summarize();
   end
endmodule
`default_nettype wire
